// ==== logic/reset_state_initializer.sv ====
// Purpose: per-cause initial values of the core register slots
// Assumes: cause inputs are asynchronous levels, core_asleep is local
// Notes: a cause loads its values on the edge after its filtered rise
`timescale 1ns/10ps
module reset_state_initializer #(
    parameter logic [7:0] FILL = reset_init_pkg::UNDEF_FILL
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    input wire logic por_event,
    input wire logic wake_event,
    input wire logic brownout_event,
    input wire logic dog_timeout,
    input wire logic external_reset_pin_n,
    input wire logic core_asleep,
    input wire reset_init_pkg::reg_req_s reg_req,
    output logic [reset_init_pkg::DATA_W-1:0] rd_data,
    output logic irq,
    output logic dog_expiry_flag,
    output logic sleep_flag
);
    logic [reset_init_pkg::NUM_CAUSES-1:0] raw_cause;
    logic [reset_init_pkg::NUM_CAUSES-1:0] rise;
    reset_init_pkg::cause_e cause_now;
    logic [7:0] slots [reset_init_pkg::NUM_SLOTS];
    logic [reset_init_pkg::NUM_CAUSES-1:0] int_status_reg;
    logic [reset_init_pkg::NUM_CAUSES-1:0] int_mask_reg;
    logic [reset_init_pkg::NUM_CAUSES-1:0] int_clear;
    logic [7:0] rd_data_reg;
    logic irq_reg;

    // Slot class by index
    function automatic reset_init_pkg::slot_cls_e slot_class(input logic [6:0] idx);
        reset_init_pkg::slot_cls_e c;
        c = reset_init_pkg::CLS_NONE;
        if (idx >= reset_init_pkg::SRAM_FIRST) begin
            c = reset_init_pkg::CLS_KEEP;
        end else if (idx >= reset_init_pkg::TIMER1_BASE) begin
            if (idx[reset_init_pkg::TMR_OFS_W-1:0] == reset_init_pkg::TMR_CNT_LO) begin
                c = reset_init_pkg::CLS_CNT_LO;
            end else begin
                c = reset_init_pkg::CLS_ZERO;
            end
        end else if (idx >= reset_init_pkg::ONES_FIRST && idx <= reset_init_pkg::ONES_LAST) begin
            c = reset_init_pkg::CLS_ONES;
        end else if (idx >= reset_init_pkg::PORT_DATA_FIRST
                     && idx <= reset_init_pkg::PORT_DATA_LAST) begin
            c = reset_init_pkg::CLS_KEEP;
        end else begin
            case (idx)
                reset_init_pkg::IDX_ACC: c = reset_init_pkg::CLS_KEEP;
                reset_init_pkg::IDX_RTC: c = reset_init_pkg::CLS_KEEP;
                reset_init_pkg::IDX_PC: c = reset_init_pkg::CLS_ONES;
                reset_init_pkg::IDX_STATUS: c = reset_init_pkg::CLS_STATUS;
                reset_init_pkg::IDX_PTR: c = reset_init_pkg::CLS_PTR;
                reset_init_pkg::IDX_OPTION: c = reset_init_pkg::CLS_ONES;
                reset_init_pkg::IDX_MODE: c = reset_init_pkg::CLS_MODE;
                reset_init_pkg::IDX_WAKE_PEND: c = reset_init_pkg::CLS_KEEP;
                reset_init_pkg::IDX_WAKE_EDGE: c = reset_init_pkg::CLS_ONES;
                reset_init_pkg::IDX_WAKE_EN: c = reset_init_pkg::CLS_ONES;
                reset_init_pkg::IDX_CMP: c = reset_init_pkg::CLS_CMP;
                reset_init_pkg::IDX_DOG: c = reset_init_pkg::CLS_KEEP;
                default: c = reset_init_pkg::CLS_NONE;
            endcase
        end
        return c;
    endfunction

    // Software-writable bits by class
    function automatic logic [7:0] wr_mask(input reset_init_pkg::slot_cls_e c);
        logic [7:0] m;
        case (c)
            reset_init_pkg::CLS_NONE: m = reset_init_pkg::ALL_ZERO;
            reset_init_pkg::CLS_STATUS: m = reset_init_pkg::STAT_WR_MASK;
            reset_init_pkg::CLS_CMP: m = reset_init_pkg::CMP_WR_MASK;
            default: m = reset_init_pkg::ALL_ONES;
        endcase
        return m;
    endfunction

    // Status value per cause
    function automatic logic [7:0] status_init(input reset_init_pkg::cause_e k,
                                               input logic [7:0] old,
                                               input logic asleep,
                                               input logic [7:0] fill);
        logic [7:0] v;
        v = old & ~reset_init_pkg::STAT_PAGE_MASK;
        case (k)
            reset_init_pkg::CAUSE_POR: begin
                v = fill & reset_init_pkg::STAT_LOW_MASK;
                {v[reset_init_pkg::STAT_TO], v[reset_init_pkg::STAT_PD]} =
                    reset_init_pkg::TOPD_POR;
            end
            reset_init_pkg::CAUSE_BOR: begin
                v = fill & ~reset_init_pkg::STAT_PAGE_MASK;
            end
            reset_init_pkg::CAUSE_WDT: begin
                if (asleep) begin
                    {v[reset_init_pkg::STAT_TO], v[reset_init_pkg::STAT_PD]} =
                        reset_init_pkg::TOPD_WDT_SLEEP;
                end else begin
                    {v[reset_init_pkg::STAT_TO], v[reset_init_pkg::STAT_PD]} =
                        reset_init_pkg::TOPD_WDT_ACTIVE;
                end
            end
            reset_init_pkg::CAUSE_PIN: begin
                if (asleep) begin
                    {v[reset_init_pkg::STAT_TO], v[reset_init_pkg::STAT_PD]} =
                        reset_init_pkg::TOPD_PIN_SLEEP;
                end
            end
            default: v = v;
        endcase
        return v;
    endfunction

    // Initial value of one slot
    function automatic logic [7:0] slot_init(input reset_init_pkg::slot_cls_e c,
                                             input reset_init_pkg::cause_e k,
                                             input logic [7:0] old,
                                             input logic asleep,
                                             input logic [7:0] fill);
        logic lost;
        logic [7:0] v;
        lost = (k == reset_init_pkg::CAUSE_POR) || (k == reset_init_pkg::CAUSE_BOR);
        case (c)
            reset_init_pkg::CLS_KEEP: v = lost ? fill : old;
            reset_init_pkg::CLS_ONES: v = reset_init_pkg::ALL_ONES;
            reset_init_pkg::CLS_MODE: v = reset_init_pkg::MODE_INIT;
            reset_init_pkg::CLS_ZERO: v = reset_init_pkg::ALL_ZERO;
            reset_init_pkg::CLS_CNT_LO: v = reset_init_pkg::CNT_LO_INIT;
            reset_init_pkg::CLS_STATUS: v = status_init(k, old, asleep, fill);
            reset_init_pkg::CLS_PTR: begin
                if (k == reset_init_pkg::CAUSE_POR) begin
                    v = fill;
                end else begin
                    v = (k == reset_init_pkg::CAUSE_BOR) ? fill : old;
                    v[reset_init_pkg::PTR_TOP] = 1'b1;
                end
            end
            reset_init_pkg::CLS_CMP: v = fill | reset_init_pkg::CMP_SET_MASK;
            default: v = old;
        endcase
        return v;
    endfunction

    // Cause inputs, pin inverted to active high
    assign raw_cause[reset_init_pkg::CB_POR] = por_event;
    assign raw_cause[reset_init_pkg::CB_WAKE] = wake_event;
    assign raw_cause[reset_init_pkg::CB_BOR] = brownout_event;
    assign raw_cause[reset_init_pkg::CB_WDT] = dog_timeout;
    assign raw_cause[reset_init_pkg::CB_PIN] = !external_reset_pin_n;

    for (genvar n = 0; n < reset_init_pkg::NUM_CAUSES; n++) begin : g_sync
        cause_sync #(
            .DEPTH(reset_init_pkg::SYNC_DEPTH)
        ) u_sync (
            .clk_sys(clk_sys),
            .resetn(resetn),
            .ce(ce),
            .raw(raw_cause[n]),
            .rise(rise[n])
        );
    end

    // Cause priority: power-on, brown-out, dog, pin, wakeup
    always_comb begin
        cause_now = reset_init_pkg::CAUSE_NONE;
        if (rise[reset_init_pkg::CB_WAKE]) begin
            cause_now = reset_init_pkg::CAUSE_WAKE;
        end
        if (rise[reset_init_pkg::CB_PIN]) begin
            cause_now = reset_init_pkg::CAUSE_PIN;
        end
        if (rise[reset_init_pkg::CB_WDT]) begin
            cause_now = reset_init_pkg::CAUSE_WDT;
        end
        if (rise[reset_init_pkg::CB_BOR]) begin
            cause_now = reset_init_pkg::CAUSE_BOR;
        end
        if (rise[reset_init_pkg::CB_POR]) begin
            cause_now = reset_init_pkg::CAUSE_POR;
        end
    end

    // Slot storage; a cause load wins over a write
    for (genvar i = 0; i < reset_init_pkg::NUM_SLOTS; i++) begin : g_slot
        localparam logic [6:0] IDX = 7'(i);
        localparam reset_init_pkg::slot_cls_e CLS = slot_class(IDX);
        localparam logic [7:0] WMASK = wr_mask(CLS);
        localparam logic [7:0] RST_VAL =
            slot_init(CLS, reset_init_pkg::CAUSE_POR, reset_init_pkg::ALL_ZERO, 1'b0, FILL);
        if (CLS == reset_init_pkg::CLS_NONE) begin : g_none
            assign slots[i] = reset_init_pkg::ALL_ZERO;
        end else begin : g_store
            logic [7:0] slot_reg;
            assign slots[i] = slot_reg;
            always_ff @(posedge clk_sys or negedge resetn) begin
                if (!resetn) begin
                    slot_reg <= RST_VAL;
                end else if (ce) begin
                    if (cause_now != reset_init_pkg::CAUSE_NONE) begin
                        slot_reg <= slot_init(CLS, cause_now, slot_reg, core_asleep, FILL);
                    end else if (reg_req.wr && reg_req.addr == IDX) begin
                        slot_reg <= (reg_req.wdata & WMASK) | (slot_reg & ~WMASK);
                    end
                end
            end
        end
    end

    // Cause event flags; set wins over clear
    assign int_clear = (reg_req.wr && reg_req.addr == reset_init_pkg::IDX_INT_STATUS)
        ? reg_req.wdata[reset_init_pkg::NUM_CAUSES-1:0] : '0;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            int_status_reg <= '0;
        end else if (ce) begin
            int_status_reg <= (int_status_reg & ~int_clear) | rise;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            int_mask_reg <= '0;
        end else if (ce && reg_req.wr && reg_req.addr == reset_init_pkg::IDX_INT_MASK) begin
            int_mask_reg <= reg_req.wdata[reset_init_pkg::NUM_CAUSES-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            irq_reg <= 1'b0;
        end else if (ce) begin
            irq_reg <= |(int_status_reg & int_mask_reg);
        end
    end

    // Read port
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rd_data_reg <= reset_init_pkg::ALL_ZERO;
        end else if (ce) begin
            if (!reg_req.rd) begin
                rd_data_reg <= reset_init_pkg::ALL_ZERO;
            end else if (reg_req.addr == reset_init_pkg::IDX_INT_STATUS) begin
                rd_data_reg <= 8'(int_status_reg);
            end else if (reg_req.addr == reset_init_pkg::IDX_INT_MASK) begin
                rd_data_reg <= 8'(int_mask_reg);
            end else begin
                rd_data_reg <= slots[reg_req.addr];
            end
        end
    end

    assign rd_data = rd_data_reg;
    assign irq = irq_reg;
    assign dog_expiry_flag = slots[reset_init_pkg::IDX_STATUS][reset_init_pkg::STAT_TO];
    assign sleep_flag = slots[reset_init_pkg::IDX_STATUS][reset_init_pkg::STAT_PD];

    // Checks
    property p_prio_por;
        @(posedge clk_sys) disable iff (!resetn)
        rise[reset_init_pkg::CB_POR] |-> cause_now == reset_init_pkg::CAUSE_POR;
    endproperty
    a_prio_por: assert property (p_prio_por) else $error("por not top priority");

    property p_fixed;
        @(posedge clk_sys) disable iff (!resetn)
        ce && cause_now != reset_init_pkg::CAUSE_NONE |=>
            slots[reset_init_pkg::IDX_PC] == reset_init_pkg::ALL_ONES
            && slots[reset_init_pkg::IDX_MODE] == reset_init_pkg::MODE_INIT
            && slots[reset_init_pkg::ONES_LAST] == reset_init_pkg::ALL_ONES;
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed values not loaded");

    property p_lost;
        @(posedge clk_sys) disable iff (!resetn)
        ce && cause_now == reset_init_pkg::CAUSE_BOR |=>
            slots[reset_init_pkg::IDX_ACC] == FILL && slots[reset_init_pkg::SRAM_FIRST] == FILL;
    endproperty
    a_lost: assert property (p_lost) else $error("brown-out kept contents");

    property p_kept;
        @(posedge clk_sys) disable iff (!resetn)
        ce && cause_now == reset_init_pkg::CAUSE_WDT |=>
            $stable(slots[reset_init_pkg::IDX_DOG]) && $stable(slots[reset_init_pkg::IDX_RTC]);
    endproperty
    a_kept: assert property (p_kept) else $error("dog reset lost contents");

    property p_wdt_sleep;
        @(posedge clk_sys) disable iff (!resetn)
        ce && cause_now == reset_init_pkg::CAUSE_WDT && core_asleep |=>
            {dog_expiry_flag, sleep_flag} == reset_init_pkg::TOPD_WDT_SLEEP;
    endproperty
    a_wdt_sleep: assert property (p_wdt_sleep) else $error("dog asleep pair wrong");

    property p_wdt_active;
        @(posedge clk_sys) disable iff (!resetn)
        ce && cause_now == reset_init_pkg::CAUSE_WDT && !core_asleep |=>
            {dog_expiry_flag, sleep_flag} == reset_init_pkg::TOPD_WDT_ACTIVE;
    endproperty
    a_wdt_active: assert property (p_wdt_active) else $error("dog active pair wrong");

    property p_pin;
        @(posedge clk_sys) disable iff (!resetn)
        ce && cause_now == reset_init_pkg::CAUSE_PIN |=>
            core_asleep
            ? {dog_expiry_flag, sleep_flag} == reset_init_pkg::TOPD_PIN_SLEEP
            : $stable({dog_expiry_flag, sleep_flag});
    endproperty
    a_pin: assert property (p_pin) else $error("pin reset pair wrong");

    property p_timer;
        @(posedge clk_sys) disable iff (!resetn)
        ce && cause_now != reset_init_pkg::CAUSE_NONE |=>
            slots[reset_init_pkg::TIMER1_BASE] == reset_init_pkg::CNT_LO_INIT
            && slots[reset_init_pkg::TIMER2_BASE] == reset_init_pkg::CNT_LO_INIT
            && slots[reset_init_pkg::TIMER2_BASE + 7'(reset_init_pkg::TMR_CNT_HI)] == 8'h00;
    endproperty
    a_timer: assert property (p_timer) else $error("timer counter not 0001");

    property p_ccr_ctrl;
        @(posedge clk_sys) disable iff (!resetn)
        ce && cause_now != reset_init_pkg::CAUSE_NONE |=>
            slots[reset_init_pkg::TIMER1_BASE + 7'(reset_init_pkg::TMR_CCR_FIRST)] == 8'h00
            && slots[reset_init_pkg::TIMER2_BASE + 7'(reset_init_pkg::TMR_CTRL_B)] == 8'h00
            && slots[reset_init_pkg::TIMER1_BASE + 7'(reset_init_pkg::TMR_CTRL_A)] == 8'h00;
    endproperty
    a_ccr_ctrl: assert property (p_ccr_ctrl) else $error("timer regs not cleared");

    property p_status_por;
        @(posedge clk_sys) disable iff (!resetn)
        ce && cause_now == reset_init_pkg::CAUSE_POR |=>
            (slots[reset_init_pkg::IDX_STATUS] & ~reset_init_pkg::STAT_LOW_MASK)
            == reset_init_pkg::STAT_POR_TOP;
    endproperty
    a_status_por: assert property (p_status_por) else $error("status after por wrong");

    property p_ptr_wake;
        @(posedge clk_sys) disable iff (!resetn)
        ce && cause_now == reset_init_pkg::CAUSE_WAKE |=>
            slots[reset_init_pkg::IDX_PTR][reset_init_pkg::PTR_TOP]
            && $stable(slots[reset_init_pkg::IDX_PTR][6:0])
            && (slots[reset_init_pkg::IDX_CMP] & reset_init_pkg::CMP_SET_MASK)
               == reset_init_pkg::CMP_SET_MASK;
    endproperty
    a_ptr_wake: assert property (p_ptr_wake) else $error("pointer or comparator wrong");

    property p_irq;
        @(posedge clk_sys) disable iff (!resetn)
        ce && |(int_status_reg & int_mask_reg) |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");
endmodule

// ==== logic/reset_init_pkg.sv ====
// Purpose: constants and types for the reset state initializer
// Assumes: 8-bit slots addressed by a 7-bit index over a plain port
// Notes: undefined contents load a fill value given as a parameter
package reset_init_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int NUM_SLOTS = 128;
    localparam int NUM_CAUSES = 5;
    localparam int SYNC_DEPTH = 3;

    // Slot indices
    localparam logic [6:0] IDX_ACC = 7'h00;
    localparam logic [6:0] IDX_RTC = 7'h01;
    localparam logic [6:0] IDX_PC = 7'h02;
    localparam logic [6:0] IDX_STATUS = 7'h03;
    localparam logic [6:0] IDX_PTR = 7'h04;
    localparam logic [6:0] IDX_OPTION = 7'h05;
    localparam logic [6:0] IDX_MODE = 7'h06;
    localparam logic [6:0] IDX_WAKE_PEND = 7'h07;
    localparam logic [6:0] IDX_WAKE_EDGE = 7'h08;
    localparam logic [6:0] IDX_WAKE_EN = 7'h09;
    localparam logic [6:0] IDX_CMP = 7'h0A;
    localparam logic [6:0] IDX_DOG = 7'h0B;
    localparam logic [6:0] IDX_INT_STATUS = 7'h0C;
    localparam logic [6:0] IDX_INT_MASK = 7'h0D;
    localparam logic [6:0] PORT_DATA_FIRST = 7'h10;
    localparam logic [6:0] PORT_DATA_LAST = 7'h14;
    localparam logic [6:0] ONES_FIRST = 7'h18;
    localparam logic [6:0] ONES_LAST = 7'h2A;
    localparam logic [6:0] TIMER1_BASE = 7'h30;
    localparam logic [6:0] TIMER2_BASE = 7'h38;
    localparam logic [6:0] SRAM_FIRST = 7'h40;
    localparam int TMR_OFS_W = 3;
    localparam logic [2:0] TMR_CNT_LO = 3'h0;
    localparam logic [2:0] TMR_CNT_HI = 3'h1;
    localparam logic [2:0] TMR_CCR_FIRST = 3'h2;
    localparam logic [2:0] TMR_CTRL_A = 3'h6;
    localparam logic [2:0] TMR_CTRL_B = 3'h7;

    // Values and fields
    localparam logic [7:0] ALL_ONES = 8'hFF;
    localparam logic [7:0] ALL_ZERO = 8'h00;
    localparam logic [7:0] MODE_INIT = 8'h1F;
    localparam logic [7:0] CNT_LO_INIT = 8'h01;
    localparam logic [7:0] UNDEF_FILL = 8'h00;
    localparam int STAT_TO = 4;
    localparam int STAT_PD = 3;
    localparam logic [7:0] STAT_LOW_MASK = 8'h07;
    localparam logic [7:0] STAT_PAGE_MASK = 8'hE0;
    localparam logic [7:0] STAT_WR_MASK = 8'hE7;
    localparam logic [7:0] STAT_POR_TOP = 8'h18;
    localparam logic [1:0] TOPD_POR = 2'h3;
    localparam logic [1:0] TOPD_WDT_SLEEP = 2'h0;
    localparam logic [1:0] TOPD_WDT_ACTIVE = 2'h1;
    localparam logic [1:0] TOPD_PIN_SLEEP = 2'h2;
    localparam int PTR_TOP = 7;
    localparam logic [7:0] CMP_SET_MASK = 8'hC1;
    localparam logic [7:0] CMP_WR_MASK = 8'hFE;

    // Cause bit positions in the event vector
    localparam int CB_POR = 0;
    localparam int CB_WAKE = 1;
    localparam int CB_BOR = 2;
    localparam int CB_WDT = 3;
    localparam int CB_PIN = 4;

    typedef enum logic [2:0] {
        CAUSE_NONE = 3'b000,
        CAUSE_POR = 3'b001,
        CAUSE_WAKE = 3'b010,
        CAUSE_BOR = 3'b011,
        CAUSE_WDT = 3'b100,
        CAUSE_PIN = 3'b101
    } cause_e;

    typedef enum logic [3:0] {
        CLS_NONE = 4'b0000,
        CLS_KEEP = 4'b0001,
        CLS_ONES = 4'b0010,
        CLS_MODE = 4'b0011,
        CLS_ZERO = 4'b0100,
        CLS_CNT_LO = 4'b0101,
        CLS_STATUS = 4'b0110,
        CLS_PTR = 4'b0111,
        CLS_CMP = 4'b1000
    } slot_cls_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;
endpackage

// ==== logic/cause_sync.sv ====
// Purpose: three-stage synchronizer with agreement filter and rise pulse
// Assumes: raw comes from outside the clock domain
// Notes: pulse holds while the clock enable is low
`timescale 1ns/10ps
module cause_sync #(
    parameter int DEPTH = 3
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    input wire logic raw,
    output logic rise
);
    logic [DEPTH-1:0] sync_reg;
    logic level_reg;
    logic rise_reg;
    logic agree;

    assign agree = sync_reg[DEPTH-1] == sync_reg[DEPTH-2];
    assign rise = rise_reg;

    // Shift chain
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sync_reg <= '0;
        end else if (ce) begin
            sync_reg <= {sync_reg[DEPTH-2:0], raw};
        end
    end

    // Filtered level and rise
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            level_reg <= 1'b0;
            rise_reg <= 1'b0;
        end else if (ce) begin
            rise_reg <= agree && sync_reg[DEPTH-1] && !level_reg;
            if (agree) begin
                level_reg <= sync_reg[DEPTH-1];
            end
        end
    end
endmodule

// ==== bench/tb.sv ====
// Purpose: self-checking bench for the reset state initializer
// Assumes: FILL set to 5A so undefined slots are told from cleared ones
// Notes: clock enable dropped once to show a frozen write
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_total++; \
    $display("wrong value at %0t: got %h exp %h", $time, (a), (e)); end end
module tb;
    logic clk_sys;
    logic resetn;
    logic [4:0] ev;
    logic asleep;
    logic ce;
    reset_init_pkg::reg_req_s req;
    logic [7:0] rd_data;
    logic irq;
    logic dog_expiry_flag;
    logic sleep_flag;
    int err_total = 0;
    int checks = 0;
    int cyc = 0;

    reset_state_initializer #(.FILL(8'h5A)) uut (.clk_sys(clk_sys), .resetn(resetn), .ce(ce),
        .por_event(ev[0]), .wake_event(ev[1]), .brownout_event(ev[2]), .dog_timeout(ev[3]),
        .external_reset_pin_n(~ev[4]), .core_asleep(asleep), .reg_req(req), .rd_data(rd_data),
        .irq(irq), .dog_expiry_flag(dog_expiry_flag), .sleep_flag(sleep_flag));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic tally_and_finish;
        if (err_total == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 6000) begin
            err_total++;
            tally_and_finish();
        end
    end

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_sys) req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_sys) req <= '0;
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        @(posedge clk_sys) req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_sys) req <= '0;
        #1 `CHK(rd_data, e)
    endtask

    task automatic fire(input int i, input logic sl);
        @(posedge clk_sys) begin
            asleep <= sl;
            ev[i] <= 1'b1;
        end
        repeat (8) @(posedge clk_sys);
        ev[i] <= 1'b0;
        repeat (8) @(posedge clk_sys);
    endtask

    task automatic t_reset_values;
        rd(7'h02, 8'hFF);
        rd(7'h06, 8'h1F);
        rd(7'h18, 8'hFF);
        rd(7'h2A, 8'hFF);
        rd(7'h30, 8'h01);
        rd(7'h39, 8'h00);
        rd(7'h3A, 8'h00);
        rd(7'h3F, 8'h00);
        rd(7'h03, 8'h1A);
        rd(7'h04, 8'h5A);
        rd(7'h0A, 8'hDB);
        rd(7'h0E, 8'h00);
    endtask

    task automatic t_wake_keeps;
        logic [6:0] ka [5] = '{7'h00, 7'h01, 7'h10, 7'h40, 7'h07};
        logic [7:0] kv [5] = '{8'h33, 8'h44, 8'h55, 8'h66, 8'h77};
        for (int i = 0; i < 5; i++) wr(ka[i], kv[i]);
        wr(7'h04, 8'h23);
        wr(7'h03, 8'hE5);
        wr(7'h02, 8'h00);
        wr(7'h06, 8'h00);
        wr(7'h32, 8'h55);
        wr(7'h38, 8'h99);
        wr(7'h36, 8'hAA);
        fire(1, 1'b0);
        for (int i = 0; i < 5; i++) rd(ka[i], kv[i]);
        rd(7'h02, 8'hFF);
        rd(7'h06, 8'h1F);
        rd(7'h03, 8'h1D);
        rd(7'h04, 8'hA3);
        rd(7'h32, 8'h00);
        rd(7'h38, 8'h01);
        rd(7'h36, 8'h00);
    endtask

    task automatic t_flag_pairs;
        int c [6] = '{3, 3, 4, 4, 3, 4};
        logic s [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        logic [1:0] e [6] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h0, 2'h0};
        for (int i = 0; i < 6; i++) begin
            fire(c[i], s[i]);
            `CHK({dog_expiry_flag, sleep_flag}, e[i])
        end
        rd(7'h03, 8'h05);
        rd(7'h00, 8'h33);
        rd(7'h04, 8'hA3);
    endtask

    task automatic t_brownout;
        fire(2, 1'b0);
        rd(7'h00, 8'h5A);
        rd(7'h40, 8'h5A);
        rd(7'h03, 8'h1A);
        rd(7'h04, 8'hDA);
        rd(7'h0A, 8'hDB);
    endtask

    task automatic t_power_on;
        wr(7'h04, 8'h11);
        wr(7'h00, 8'h22);
        fire(0, 1'b0);
        rd(7'h04, 8'h5A);
        rd(7'h03, 8'h1A);
        rd(7'h00, 8'h5A);
        `CHK({dog_expiry_flag, sleep_flag}, 2'h3)
    endtask

    task automatic t_freeze;
        @(posedge clk_sys) ce <= 1'b0;
        wr(7'h00, 8'hC3);
        @(posedge clk_sys) ce <= 1'b1;
        rd(7'h00, 8'h5A);
    endtask

    task automatic t_interrupt;
        rd(7'h0C, 8'h1F);
        `CHK(irq, 1'b0)
        wr(7'h0D, 8'h08);
        repeat (3) @(posedge clk_sys);
        `CHK(irq, 1'b1)
        wr(7'h0C, 8'h08);
        repeat (3) @(posedge clk_sys);
        `CHK(irq, 1'b0)
        rd(7'h0C, 8'h17);
    endtask

    initial begin
        resetn = 1'b0;
        ev = 5'h00;
        asleep = 1'b0;
        ce = 1'b1;
        req = '0;
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        t_reset_values();
        t_wake_keeps();
        t_flag_pairs();
        t_brownout();
        t_power_on();
        t_freeze();
        t_interrupt();
        tally_and_finish();
    end
endmodule
